// ==== hdl/apms_sequencer.sv ====
// Power-mode sequencer: tracks the power field, conversion activity, power-up timing.
// Assumes write strobe, data and conversion pins are synchronous to CLK_I.
// How it works
// (RULE_01) Autostandby: enter standby after each conversion, reference stays powered.
// (RULE_02) Entering standby puts track-and-hold into hold while standby lasts.
// (RULE_03) Only the next conversion-start rising edge leaves standby and resumes track.
// (RULE_04) Host waits 600 ns external or 7 us internal reference after waking.
// (RULE_05) Write selecting full shutdown powers all down on strobe rise, hold too.
// (RULE_06) Control register contents kept through full shutdown.
// (RULE_07) Full shutdown lasts until a write changes the field; start edges ignored.
// (RULE_08) Write of normal mode during shutdown powers up and resumes track.
// (RULE_09) Host allows 10 ms after full shutdown before conversion-start falls.
// (RULE_10) Busy output shows conversion in progress; its fall marks completion.
// (RULE_11) DMA host services each result before the next conversion ends.
// (RULE_12) Host keeps conversion clock at or below 10 MHz.
// (RULE_13) Reset loads normal mode; normal mode stays fully powered.
// (RULE_14) After reset hold; first conversion-start rise moves into track.
// (RULE_15) Autoshutdown: full shutdown after conversion, wake on rise, 10 ms.
// (RULE_16) Counter times power-up; power-good only after the mode's interval.
`timescale 1ns/1ps
module apms_sequencer
  import apms_pkg::*;
#(
  parameter int unsigned PU_SHDN_CYC = PU_SHUTDOWN_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  input  wire logic       WR_N_I,
  input  wire logic [1:0] PM_DATA_I,
  input  wire logic       CONVERSION_START_N_I,
  input  wire logic       CONVERSION_CLOCK_IN_I,
  input  wire logic       INT_REF_I,
  output apms_pkg::apms_pm_t PM_O,
  output logic            BUSY_O,
  output logic            HOLD_O,
  output logic            CORE_PWR_O,
  output logic            REF_PWR_O,
  output logic            POWER_GOOD_O
);
  import apms_pkg::*;

  initial begin
    if (PU_SHDN_CYC < 1 || PU_SHDN_CYC >= (1 << CNT_W)) begin
      $error("PU_SHDN_CYC out of range");
    end
    if (CONV_EDGES < 1 || CONV_EDGES >= (1 << EDGE_W)) begin
      $error("CONV_EDGES does not fit the edge counter");
    end
    if (PU_INT_REF_CYC < 1 || PU_INT_REF_CYC >= (1 << CNT_W)) begin
      $error("PU_INT_REF_CYC does not fit the power-up counter");
    end
    if (PU_EXT_REF_CYC < 1 || PU_EXT_REF_CYC >= (1 << CNT_W)) begin
      $error("PU_EXT_REF_CYC does not fit the power-up counter");
    end
  end

  // Counts round up, so every wait lasts at least its stated minimum
  localparam logic [CNT_W-1:0]  EXT_CYC  = CNT_W'(PU_EXT_REF_CYC);
  localparam logic [CNT_W-1:0]  INT_CYC  = CNT_W'(PU_INT_REF_CYC);
  localparam logic [CNT_W-1:0]  SHDN_CYC = CNT_W'(PU_SHDN_CYC);
  localparam logic [EDGE_W-1:0] CONV_N   = EDGE_W'(CONV_EDGES);

  // Edge count restarts at each start fall that begins a conversion, so a cut conversion carries nothing over
  typedef struct packed {
    apms_state_t       state;
    apms_pm_t          pm;
    logic              hold;
    logic              busy;
    logic [EDGE_W-1:0] edges;
    logic [CNT_W-1:0]  wait_cnt;
    logic              pgood;
    logic              core_pwr;
    logic              ref_pwr;
  } apms_seq_st_t;
  apms_seq_st_t st_r, st_nxt;

  logic     cs_rise, cs_fall, wr_rise, ck_rise;
  // Field as presented; it counts only on the strobe's rising edge
  apms_pm_t wr_pm;
  assign wr_pm = apms_pm_t'(PM_DATA_I);

  // Pins are synchronous, so one sample of history is enough to find edges
  apms_edge u_cs_edge (
    .clk_i     (CLK_I),
    .nrst_i    (NRST_I),
    .sig_i     (CONVERSION_START_N_I),
    .rise_o    (cs_rise),
    .fall_o    (cs_fall)
  );
  apms_edge u_wr_edge (
    .clk_i     (CLK_I),
    .nrst_i    (NRST_I),
    .sig_i     (WR_N_I),
    .rise_o    (wr_rise),
    .fall_o    ()
  );
  apms_edge u_ck_edge (
    .clk_i     (CLK_I),
    .nrst_i    (NRST_I),
    .sig_i     (CONVERSION_CLOCK_IN_I),
    .rise_o    (ck_rise),
    .fall_o    ()
  );

  always_comb begin
    st_nxt = st_r;
    // Power-up countdown runs in any state
    // Power-good rises only as the count runs out; losing power clears it
    if (st_r.wait_cnt != '0) begin
      st_nxt.wait_cnt = st_r.wait_cnt - CNT_W'(1);
      st_nxt.pgood    = (st_r.wait_cnt == CNT_W'(1)); // RULE_16
    end
    unique case (st_r.state)
      APMS_ST_POWERED, APMS_ST_WAKING: begin
        if (cs_rise) begin
          st_nxt.hold = 1'b0; // RULE_14
        end
        if (cs_fall) begin
          st_nxt.state = APMS_ST_CONVERT;
          st_nxt.hold  = 1'b1;
          st_nxt.busy  = 1'b1;
          st_nxt.edges = '0;
        end
      end
      APMS_ST_CONVERT: begin
        // Hold stays on until the last conversion-clock edge of the conversion
        if (ck_rise) begin
          st_nxt.edges = st_r.edges + EDGE_W'(1);
          if (st_r.edges == CONV_N - EDGE_W'(1)) begin
            st_nxt.busy = 1'b0; // RULE_10
            unique case (st_r.pm)
              APMS_PM_AUTO_STBY: begin
                st_nxt.state    = APMS_ST_STANDBY; // RULE_01
                st_nxt.core_pwr = 1'b0;
                st_nxt.pgood    = 1'b0;
                st_nxt.hold     = 1'b1; // RULE_02
              end
              APMS_PM_AUTO_SHDN: begin
                st_nxt.state    = APMS_ST_SHUTDOWN; // RULE_15
                st_nxt.core_pwr = 1'b0;
                st_nxt.ref_pwr  = 1'b0;
                st_nxt.pgood    = 1'b0;
                st_nxt.hold     = 1'b1;
              end
              default: begin
                st_nxt.state = APMS_ST_POWERED; // RULE_13
                st_nxt.hold  = 1'b0;
              end
            endcase
          end
        end
      end
      APMS_ST_STANDBY: begin
        // Reference stayed up, so the wait depends only on which reference is used
        if (cs_rise) begin
          st_nxt.state    = APMS_ST_WAKING; // RULE_03
          st_nxt.hold     = 1'b0;
          st_nxt.core_pwr = 1'b1;
          st_nxt.wait_cnt = INT_REF_I ? INT_CYC : EXT_CYC; // RULE_16
        end
      end
      APMS_ST_SHUTDOWN: begin
        // Start edges wake only the per-conversion shutdown, not the written one
        // A rewrite of the field after an automatic shutdown must not strand it here
        if (cs_rise && st_r.pm != APMS_PM_FULL_SHDN) begin // RULE_07
          st_nxt.state    = APMS_ST_WAKING; // RULE_15
          st_nxt.hold     = 1'b0;
          st_nxt.core_pwr = 1'b1;
          st_nxt.ref_pwr  = 1'b1;
          st_nxt.wait_cnt = SHDN_CYC;
        end
      end
      default: begin
        st_nxt.state = APMS_ST_POWERED;
      end
    endcase
    // A write is taken on the strobe's rising edge and wins over conversion events
    if (wr_rise) begin
      st_nxt.pm = wr_pm; // RULE_06
      if (wr_pm == APMS_PM_FULL_SHDN) begin
        st_nxt.state    = APMS_ST_SHUTDOWN; // RULE_05
        st_nxt.core_pwr = 1'b0;
        st_nxt.ref_pwr  = 1'b0;
        st_nxt.pgood    = 1'b0;
        st_nxt.hold     = 1'b1;
        st_nxt.busy     = 1'b0;
        st_nxt.wait_cnt = '0;
      end else if (st_r.state == APMS_ST_SHUTDOWN && st_r.pm == APMS_PM_FULL_SHDN) begin
        // Any change of the field leaves full shutdown
        st_nxt.state    = APMS_ST_WAKING; // RULE_08
        st_nxt.hold     = 1'b0;
        st_nxt.core_pwr = 1'b1;
        st_nxt.ref_pwr  = 1'b1;
        st_nxt.wait_cnt = SHDN_CYC; // RULE_09
      end
    end
    // Waking ends when the count is spent; power-good follows in the same edge
    if (st_nxt.state == APMS_ST_WAKING && st_nxt.wait_cnt == '0) begin
      st_nxt.state = APMS_ST_POWERED;
    end
  end

  // Reset keeps hold on until the first start rise, with full power in normal mode
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_r.state    <= APMS_ST_POWERED;
      st_r.pm       <= PM_RESET; // RULE_13
      st_r.hold     <= 1'b1; // RULE_14
      st_r.busy     <= 1'b0;
      st_r.edges    <= '0;
      st_r.wait_cnt <= '0;
      st_r.pgood    <= 1'b1;
      st_r.core_pwr <= 1'b1;
      st_r.ref_pwr  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PM_O         = st_r.pm;
  assign BUSY_O       = st_r.busy;
  assign HOLD_O       = st_r.hold;
  assign CORE_PWR_O   = st_r.core_pwr;
  assign REF_PWR_O    = st_r.ref_pwr;
  assign POWER_GOOD_O = st_r.pgood;
endmodule : apms_sequencer

// ==== hdl/apms_pkg.sv ====
// Constants and types for the converter power-mode sequencer.
// Assumes a single 50 MHz clock; all pins arrive synchronous to it.
package apms_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 20000;
  // Power-up intervals in their own units
  localparam int unsigned PU_EXT_REF_NS     = 600;
  localparam int unsigned PU_INT_REF_US     = 7;
  localparam int unsigned PU_SHUTDOWN_MS    = 10;
  // Least times round up to whole cycles
  localparam int unsigned PU_EXT_REF_CYC    = (PU_EXT_REF_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
  localparam int unsigned PU_INT_REF_CYC    = (PU_INT_REF_US * 1000000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
  localparam int unsigned PU_SHUTDOWN_CYC   = 500000;  // 10 ms at 20 ns, see PU_SHUTDOWN_MS
  localparam int unsigned CNT_W             = 20;
  // Conversion length in conversion-clock rising edges
  localparam int unsigned CONV_EDGES        = 13;
  localparam int unsigned EDGE_W            = 4;

  typedef enum logic [1:0] {
    APMS_PM_NORMAL    = 2'b00,
    APMS_PM_AUTO_SHDN = 2'b01,
    APMS_PM_AUTO_STBY = 2'b10,
    APMS_PM_FULL_SHDN = 2'b11
  } apms_pm_t;
  localparam apms_pm_t PM_RESET = APMS_PM_NORMAL;

  typedef enum logic [2:0] {
    APMS_ST_POWERED  = 3'b000,
    APMS_ST_CONVERT  = 3'b001,
    APMS_ST_STANDBY  = 3'b010,
    APMS_ST_SHUTDOWN = 3'b011,
    APMS_ST_WAKING   = 3'b100
  } apms_state_t;
endpackage : apms_pkg

// ==== hdl/apms_edge.sv ====
// Rising/falling edge detector for one synchronous pin.
// Assumes the input is already synchronous to CLK_I.
`timescale 1ns/1ps
module apms_edge (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic sig_i,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic prev;
  } apms_edge_st_t;
  apms_edge_st_t st_r, st_nxt;

  always_comb begin
    st_nxt.prev = sig_i;
  end

  // Reset copies the pin, so a level held through reset never reads as an edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r.prev <= sig_i;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise_o = sig_i & ~st_r.prev;
  assign fall_o = ~sig_i & st_r.prev;
endmodule : apms_edge

// ==== dv/apms_seq_sva.sv ====
// Port assertions for the power-mode sequencer.
// Bound onto apms_sequencer; one clock domain.
`timescale 1ns/1ps
module apms_seq_sva
  import apms_pkg::*;
#(parameter int unsigned PU_SHDN_CYC = 20) (
  input logic       CLK_I,
  input logic       NRST_I,
  input logic       WR_N_I,
  input logic [1:0] PM_DATA_I,
  input logic       CONVERSION_START_N_I,
  input logic       INT_REF_I,
  input apms_pm_t   PM_O,
  input logic       BUSY_O,
  input logic       HOLD_O,
  input logic       CORE_PWR_O,
  input logic       REF_PWR_O,
  input logic       POWER_GOOD_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic stby;
  assign stby = PM_O == APMS_PM_AUTO_STBY && !CORE_PWR_O;
  // A write in the same cycle wins, so it is kept out of the wake trigger
  sequence s_rise; $rose(CONVERSION_START_N_I) && !$rose(WR_N_I) && $past(NRST_I); endsequence
  sequence s_pg_ext; (!POWER_GOOD_O throughout ##27 1) ##[1:6] POWER_GOOD_O; endsequence
  AST_STBY_ENTRY: assert property (
    PM_O == APMS_PM_AUTO_STBY && $fell(BUSY_O) |-> !CORE_PWR_O && REF_PWR_O && HOLD_O)
    else $error("standby entry");
  AST_STBY_STAY: assert property (
    stby && !$rose(CONVERSION_START_N_I) && !$rose(WR_N_I) |=> !CORE_PWR_O && HOLD_O)
    else $error("standby left");
  AST_WAKE: assert property (
    stby ##0 s_rise |=> CORE_PWR_O && !HOLD_O) else $error("no wake");
  AST_SHDN_WRITE: assert property (
    $rose(WR_N_I) && PM_DATA_I == 2'h3 && $past(NRST_I) |=> PM_O == APMS_PM_FULL_SHDN
    && !CORE_PWR_O && !REF_PWR_O && HOLD_O) else $error("shutdown write");
  AST_SHDN_STAY: assert property (
    PM_O == APMS_PM_FULL_SHDN && !$rose(WR_N_I) |=> PM_O == APMS_PM_FULL_SHDN
    && !CORE_PWR_O && HOLD_O) else $error("shutdown left");
  AST_SHDN_WAKE: assert property (
    PM_O == APMS_PM_FULL_SHDN && $rose(WR_N_I) && PM_DATA_I == 2'h0 |=> PM_O == APMS_PM_NORMAL
    && CORE_PWR_O && !HOLD_O) else $error("shutdown wake");
  AST_BUSY_START: assert property (
    PM_O == APMS_PM_NORMAL && CORE_PWR_O && !BUSY_O && $fell(CONVERSION_START_N_I)
    && !$rose(WR_N_I) && $past(NRST_I) |=> BUSY_O && HOLD_O) else $error("busy start");
  AST_PG_EXT: assert property (
    $rose(CORE_PWR_O) && PM_O == APMS_PM_AUTO_STBY && !INT_REF_I |-> s_pg_ext)
    else $error("power good timing");
endmodule : apms_seq_sva

bind apms_sequencer apms_seq_sva #(.PU_SHDN_CYC(PU_SHDN_CYC)) i_apms_seq_sva (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .WR_N_I(WR_N_I), .PM_DATA_I(PM_DATA_I),
  .CONVERSION_START_N_I(CONVERSION_START_N_I), .INT_REF_I(INT_REF_I), .PM_O(PM_O),
  .BUSY_O(BUSY_O), .HOLD_O(HOLD_O), .CORE_PWR_O(CORE_PWR_O), .REF_PWR_O(REF_PWR_O),
  .POWER_GOOD_O(POWER_GOOD_O));

// ==== dv/apms_host_model.sv ====
// Host model: conversion clock source and end-of-conversion reader.
// Assumes busy_i comes from the sequencer on the same clock.
`timescale 1ns/1ps
module apms_host_model #(
  parameter int HALF = 3
) (
  input  wire logic clk_i,
  input  wire logic busy_i,
  output logic      cclk_o,
  output int        reads_o
);
  int   cnt;
  logic busy_q;
  initial begin
    cclk_o = 1'b0;
    reads_o = 0;
    cnt = 0;
    busy_q = 1'b0;
  end
  // Clock stands low between conversions; six cycles a period stays under 10 MHz
  always @(negedge clk_i) begin
    busy_q <= busy_i;
    cnt <= (busy_i && cnt < HALF - 1) ? cnt + 1 : 0;
    if (!busy_i) cclk_o <= 1'b0;
    else if (cnt == HALF - 1) cclk_o <= ~cclk_o;
    if (busy_q && !busy_i) reads_o <= reads_o + 1;
  end
endmodule : apms_host_model

// ==== dv/adc_power_mode_sequencer_tb_top.sv ====
// Bench for the power-mode sequencer: each power mode in turn.
// Host model makes the conversion clock; shutdown wait is shortened.
`timescale 1ns/1ps
module adc_power_mode_sequencer_tb_top;
  import apms_pkg::*;
  localparam int SHDN = 20;
  logic       clk, nrst_n, wr_n, start_n, cclk, int_ref, busy, hold, core, refp, pg;
  logic [1:0] pm_data;
  apms_pm_t   pm;
  logic [6:0] st;
  int         error_cnt, samples_checked, reads;
  assign st = {pm, busy, hold, core, refp, pg};
  apms_sequencer #(.PU_SHDN_CYC(SHDN)) i_apms_sequencer (
    .CLK_I(clk), .NRST_I(nrst_n), .WR_N_I(wr_n), .PM_DATA_I(pm_data),
    .CONVERSION_START_N_I(start_n), .CONVERSION_CLOCK_IN_I(cclk), .INT_REF_I(int_ref),
    .PM_O(pm), .BUSY_O(busy), .HOLD_O(hold), .CORE_PWR_O(core), .REF_PWR_O(refp),
    .POWER_GOOD_O(pg));
  apms_host_model i_apms_host_model (
    .clk_i(clk), .busy_i(busy), .cclk_o(cclk), .reads_o(reads));
  task automatic results();
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input bit sel, input logic v, output int n);
    for (n = 0; n < 2000; n++) begin
      if ((sel ? pg : busy) === v) return;
      @(negedge clk);
    end
    error_cnt++;
    results();
  endtask : wt
  task automatic wr(input logic [1:0] v, input logic [6:0] e);
    wr_n = 1'b0;
    pm_data = v;
    @(negedge clk);
    wr_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(st, e);
  endtask : wr
  task automatic conv(input logic [6:0] e_busy, input logic [6:0] e_end);
    int n;
    start_n = 1'b0;
    wt(1'b0, 1'b1, n);
    chk(st, e_busy);
    wt(1'b0, 1'b0, n);
    chk(st, e_end);
  endtask : conv
  task automatic pg_wait(input int cyc);
    int n;
    wt(1'b1, 1'b1, n);
    chk({6'h00, n >= cyc - 3 && n <= cyc + 2}, 7'h01);
  endtask : pg_wait
  task automatic wake(input logic [6:0] e, input int cyc);
    start_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(st, e);
    pg_wait(cyc);
  endtask : wake
  task automatic t_normal();
    chk(st, 7'h0f);
    start_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(st, 7'h07);
    conv(7'h1f, 7'h07);
    start_n = 1'b1;
    @(negedge clk);
  endtask : t_normal
  task automatic t_stby();
    wr(2'h2, 7'h47);
    for (int i = 0; i < 2; i++) begin
      int_ref = i[0];
      conv(7'h5f, 7'h4a);
      repeat (10) @(negedge clk);
      chk(st, 7'h4a);
      wake(7'h46, i ? PU_INT_REF_CYC : PU_EXT_REF_CYC);
    end
  endtask : t_stby
  task automatic t_shdn();
    wr(2'h3, 7'h68);
    start_n = 1'b0;
    repeat (3) @(negedge clk);
    start_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(st, 7'h68);
    wr(2'h0, 7'h06);
    pg_wait(SHDN);
    conv(7'h1f, 7'h07);
    start_n = 1'b1;
    @(negedge clk);
  endtask : t_shdn
  task automatic t_ashdn();
    wr(2'h1, 7'h27);
    conv(7'h3f, 7'h28);
    wake(7'h26, SHDN);
  endtask : t_ashdn
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    nrst_n = 1'b0;
    wr_n = 1'b1;
    pm_data = 2'h0;
    // Start held low through reset, so its first rise is what leaves hold
    start_n = 1'b0;
    int_ref = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk);
    nrst_n = 1'b1;
    @(negedge clk);
    t_normal();
    t_stby();
    t_shdn();
    t_ashdn();
    chk(7'(reads), 7'h05);
    results();
  end
endmodule : adc_power_mode_sequencer_tb_top
